//--- hdl/bbc_regs.svh
// Opcode encodings, field positions and cycle counts for the branch/bit/control decoder
`ifndef BBC_REGS_SVH
`define BBC_REGS_SVH
`define BBC_COL_REL_MASK 4'h1
`define BBC_COL_REL_VAL 4'h0
`define BBC_COL_CALL 4'h1
`define BBC_COL_JUMP 4'h9
`define BBC_COL_BTB 4'h3
`define BBC_COL_BSC 4'hb
`define BBC_OP_NOP 8'h04
`define BBC_OP_RET 8'hcd
`define BBC_OP_INTERRUPT_RETURN 8'h4d
`define BBC_OP_STOP 8'h6d
`define BBC_OP_WAIT 8'hed
`define BBC_COND_NZ 3'h0
`define BBC_COND_NC 3'h2
`define BBC_COND_Z 3'h4
`define BBC_COND_C 3'h6
`define BBC_CYC_REL 3'h2
`define BBC_CYC_BTB 3'h5
`define BBC_CYC_BSC 3'h4
`define BBC_CYC_CTRL 3'h2
`define BBC_CYC_LONG 3'h4
`define BBC_CYC_EXT 3'h2
`define BBC_REL_BIAS 12'h001
`define BBC_BTB_BIAS 12'h002
`define BBC_LEN_BTB 12'h003
`define BBC_LEN_BSC 12'h002
`define BBC_LEN_ONE 12'h001
`define BBC_RESET_PC 12'h000
`define BBC_STACK_DEPTH 6
`endif

//--- hdl/bbc_pkg.sv
// Types shared by the branch/bit/control decoder files
package bbc_pkg;
    typedef enum logic [3:0] {
        CL_NOP = 4'h0, CL_REL = 4'h1, CL_BTB = 4'h2, CL_BSC = 4'h3,
        CL_JUMP = 4'h4, CL_CALL = 4'h5, CL_RET = 4'h6, CL_INTERRUPT_RETURN = 4'h7,
        CL_STOP = 4'h8, CL_WAIT = 4'h9, CL_EXT = 4'ha
    } bbc_class_e;
    typedef enum logic {ST_RUN = 1'b0, ST_HALT = 1'b1} bbc_state_e;
    typedef struct packed {
        logic z;
        logic c;
    } bbc_flags_s;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bbc_dbus_s;
    typedef logic [11:0] bbc_pc_t;
endpackage : bbc_pkg

//--- hdl/bbc_ret_stack.sv
// Return address stack held in flip-flops
`timescale 1ns/100ps
`include "bbc_regs.svh"
module bbc_ret_stack import bbc_pkg::*; #(
    parameter int DEPTH = `BBC_STACK_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Stack operations
    input wire logic push_i,
    input wire logic pop_i,
    input wire bbc_pc_t push_pc_i,
    output bbc_pc_t top_o
);
    localparam int PW = $clog2(DEPTH);
    bbc_pc_t mem_q [DEPTH];
    logic [PW-1:0] ptr_q;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : wrap_inc

    function automatic logic [PW-1:0] wrap_dec(input logic [PW-1:0] p);
        wrap_dec = (p == '0) ? PW'(DEPTH - 1) : p - 1'b1;
    endfunction : wrap_dec

    // Overflow wraps and overwrites the oldest entry, as a small stack does
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ptr_q <= '0;
        end else if (ce_i && push_i) begin
            ptr_q <= wrap_inc(ptr_q);
        end else if (ce_i && pop_i) begin
            ptr_q <= wrap_dec(ptr_q);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i && push_i) begin
            mem_q[ptr_q] <= push_pc_i;
        end
    end

    assign top_o = mem_q[wrap_dec(ptr_q)];
endmodule : bbc_ret_stack

//--- hdl/bbc_decoder.sv
// Decode and execute of relative branches, bit ops, control ops and long jumps
`timescale 1ns/100ps
`include "bbc_regs.svh"
module bbc_decoder import bbc_pkg::*; (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Program memory
    output bbc_pc_t pm_addr_o,
    input wire logic [7:0] pm_data_i,
    // Data space
    output bbc_dbus_s ds_o,
    input wire logic [7:0] ds_rdata_i,
    // Core status and control
    input wire logic wdog_sel_i,
    input wire logic wake_i,
    input wire bbc_flags_s saved_flags_i,
    output bbc_flags_s flags_o,
    output logic stop_o,
    output logic wait_o,
    output logic ext_valid_o,
    output logic [7:0] ext_opcode_o
);
    bbc_state_e state_q;
    bbc_pc_t pc_q;
    logic [2:0] cyc_q;
    logic [7:0] opc_q;
    logic [7:0] op2_q;
    logic [7:0] rdh_q;
    bbc_class_e cls_q;
    bbc_pc_t stack_top;
    logic [7:0] op;
    bbc_class_e cls;
    logic run;
    logic last;
    logic [2:0] bsel;
    logic [7:0] bmask;
    bbc_pc_t next_pc;
    bbc_pc_t jp_tgt;

    function automatic bbc_class_e classify(input logic [7:0] o);
        if (o == `BBC_OP_NOP) classify = CL_NOP;
        else if (o == `BBC_OP_RET) classify = CL_RET;
        else if (o == `BBC_OP_INTERRUPT_RETURN) classify = CL_INTERRUPT_RETURN;
        else if (o == `BBC_OP_STOP) classify = CL_STOP;
        else if (o == `BBC_OP_WAIT) classify = CL_WAIT;
        else if ((o[3:0] & `BBC_COL_REL_MASK) == `BBC_COL_REL_VAL) classify = CL_REL;
        else if (o[3:0] == `BBC_COL_CALL) classify = CL_CALL;
        else if (o[3:0] == `BBC_COL_JUMP) classify = CL_JUMP;
        else if (o[3:0] == `BBC_COL_BTB) classify = CL_BTB;
        else if (o[3:0] == `BBC_COL_BSC) classify = CL_BSC;
        else classify = CL_EXT;
    endfunction : classify

    function automatic logic [2:0] cycles_of(input bbc_class_e c);
        case (c)
            CL_REL: cycles_of = `BBC_CYC_REL;
            CL_BTB: cycles_of = `BBC_CYC_BTB;
            CL_BSC: cycles_of = `BBC_CYC_BSC;
            CL_JUMP, CL_CALL: cycles_of = `BBC_CYC_LONG;
            CL_EXT: cycles_of = `BBC_CYC_EXT;
            default: cycles_of = `BBC_CYC_CTRL;
        endcase
    endfunction : cycles_of

    function automatic logic cond_met(input logic [2:0] k, input bbc_flags_s f);
        case (k)
            `BBC_COND_NZ: cond_met = !f.z;
            `BBC_COND_NC: cond_met = !f.c;
            `BBC_COND_Z: cond_met = f.z;
            `BBC_COND_C: cond_met = f.c;
            default: cond_met = 1'b0;
        endcase
    endfunction : cond_met

    // Opcode is live on the bus in cycle 0, held afterwards
    assign run = (state_q == ST_RUN);
    assign op = (cyc_q == 3'h0) ? pm_data_i : opc_q;
    assign cls = (cyc_q == 3'h0) ? classify(pm_data_i) : cls_q;
    assign last = run && (cyc_q == cycles_of(cls) - 3'h1);
    assign bsel = {op[5], op[6], op[7]};
    assign bmask = 8'h01 << bsel;
    assign jp_tgt = {opc_q[7:4], pm_data_i};

    always_comb begin
        next_pc = pc_q + `BBC_LEN_ONE;
        case (cls)
            CL_REL: begin
                // Signed span plus one gives -15..+16 around the branch
                if (cond_met(op[2:0], flags_o)) begin
                    next_pc = pc_q + `BBC_REL_BIAS + {{7{op[7]}}, op[7:3]};
                end
            end
            CL_BTB: begin
                // Carry already holds the tested bit by the last cycle
                if (flags_o.c == op[4]) begin
                    next_pc = pc_q + `BBC_BTB_BIAS + {{4{op2_q[7]}}, op2_q};
                end else begin
                    next_pc = pc_q + `BBC_LEN_BTB;
                end
            end
            CL_BSC: next_pc = pc_q + `BBC_LEN_BSC;
            CL_JUMP, CL_CALL: next_pc = {opc_q[7:4], op2_q};
            CL_RET, CL_INTERRUPT_RETURN: next_pc = stack_top;
            default: next_pc = pc_q + `BBC_LEN_ONE;
        endcase
    end

    bbc_ret_stack #(
        .DEPTH(`BBC_STACK_DEPTH)
    ) u_stack (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .push_i(last && cls == CL_CALL),
        .pop_i(last && (cls == CL_RET || cls == CL_INTERRUPT_RETURN)),
        .push_pc_i(pc_q + `BBC_LEN_BSC),
        .top_o(stack_top)
    );

    // Sequencing and program counter
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_q <= ST_RUN;
            cyc_q <= 3'h0;
            pc_q <= `BBC_RESET_PC;
            pm_addr_o <= `BBC_RESET_PC;
            opc_q <= 8'h00;
            cls_q <= CL_NOP;
            op2_q <= 8'h00;
        end else if (ce_i) begin
            case (state_q)
                ST_RUN: begin
                    if (cyc_q == 3'h0) begin
                        opc_q <= pm_data_i;
                        cls_q <= cls;
                    end
                    // Only the bit test has a third byte; a long target keeps byte two
                    if (cyc_q == 3'h1 || (cyc_q == 3'h2 && cls == CL_BTB)) begin
                        op2_q <= pm_data_i;
                    end
                    if (last) begin
                        cyc_q <= 3'h0;
                        pc_q <= next_pc;
                        pm_addr_o <= next_pc;
                        if (cls == CL_STOP || cls == CL_WAIT) begin
                            state_q <= ST_HALT;
                        end
                    end else begin
                        cyc_q <= cyc_q + 3'h1;
                        pm_addr_o <= pm_addr_o + `BBC_LEN_ONE;
                    end
                end
                ST_HALT: begin
                    if (wake_i) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Low-power requests; the watchdog forbids a real stop
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            stop_o <= 1'b0;
            wait_o <= 1'b0;
        end else if (ce_i) begin
            if (last && cls == CL_STOP && !wdog_sel_i) begin
                stop_o <= 1'b1;
            end else if (last && (cls == CL_WAIT || cls == CL_STOP)) begin
                wait_o <= 1'b1;
            end else if (state_q == ST_HALT && wake_i) begin
                stop_o <= 1'b0;
                wait_o <= 1'b0;
            end
        end
    end

    // Flags change only on bit test (carry) and interrupt return
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            flags_o <= '0;
        end else if (ce_i) begin
            if (run && cls == CL_BTB && cyc_q == 3'h3) begin
                flags_o.c <= ds_rdata_i[bsel];
            end else if (last && cls == CL_INTERRUPT_RETURN) begin
                flags_o <= saved_flags_i;
            end
        end
    end

    // Data space read then single-bit write back
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ds_o <= '0;
            rdh_q <= 8'h00;
        end else if (ce_i) begin
            ds_o.rd <= run && cyc_q == 3'h1 && (cls == CL_BTB || cls == CL_BSC);
            ds_o.wr <= 1'b0;
            if (run && cyc_q == 3'h1 && (cls == CL_BTB || cls == CL_BSC)) begin
                ds_o.addr <= pm_data_i;
            end
            if (run && cyc_q == 3'h3 && cls == CL_BSC) begin
                // Whole byte is rewritten, so volatile bits elsewhere may be lost
                rdh_q <= ds_rdata_i;
                ds_o.wr <= 1'b1;
                ds_o.wdata <= op[4] ? (ds_rdata_i | bmask) : (ds_rdata_i & ~bmask);
            end
        end
    end

    // Opcodes outside this group are handed on
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ext_valid_o <= 1'b0;
            ext_opcode_o <= 8'h00;
        end else if (ce_i) begin
            ext_valid_o <= run && cyc_q == 3'h0 && cls == CL_EXT;
            if (run && cyc_q == 3'h0) begin
                ext_opcode_o <= pm_data_i;
            end
        end
    end

    logic start;
    assign start = run && cyc_q == 3'h0;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    rel_two_cycles_a: assert property (start && cls == CL_REL |=> cyc_q == 3'h1 ##1 cyc_q == 3'h0)
        else $error("relative branch not two cycles");
    rel_flags_kept_a: assert property (start && cls == CL_REL |=> flags_o == $past(flags_o) ##1 $stable(flags_o))
        else $error("relative branch touched flags");
    btb_five_cycles_a: assert property (start && cls == CL_BTB |=>
        cyc_q == 3'h1 ##3 cyc_q == 3'h4 ##1 cyc_q == 3'h0)
        else $error("bit test not five cycles");
    btb_carry_copy_a: assert property (run && cls == CL_BTB && cyc_q == 3'h3 |=> flags_o.c == $past(ds_rdata_i[bsel]) && flags_o.z == $past(flags_o.z))
        else $error("tested bit not in carry");
    bsc_write_time_a: assert property (start && cls == CL_BSC |=> !ds_o.wr [*3] ##1 ds_o.wr)
        else $error("bit op write not at cycle four");
    bsc_one_bit_a: assert property (ds_o.wr |-> $onehot(ds_o.wdata ^ rdh_q) || ds_o.wdata == rdh_q)
        else $error("bit op changed more than one bit");
    stop_to_wait_a: assert property (start && cls == CL_STOP && wdog_sel_i |-> ##2 wait_o && !stop_o)
        else $error("stop not replaced by wait");
    jump_target_a: assert property (run && cyc_q == 3'h1 && (cls_q == CL_JUMP || cls_q == CL_CALL) |-> ##3 pm_addr_o == $past(jp_tgt, 3))
        else $error("long target wrong");

    rel_taken_c: cover property (start && cls == CL_REL ##2 pm_addr_o != $past(pc_q, 2) + 12'h001);
    btb_run_c: cover property (start && cls == CL_BTB ##5 start);
    call_ret_c: cover property (start && cls == CL_CALL ##4 start && cls == CL_RET);
    stop_c: cover property (stop_o);
endmodule : bbc_decoder

//--- bench/bbc_mem_model.sv
// Program memory and data space model facing the decoder
`timescale 1ns/100ps
module bbc_mem_model import bbc_pkg::*; (
    // Clock
    input wire logic mclk_i,
    // Program side
    input wire bbc_pc_t pm_addr_i,
    output logic [7:0] pm_data_o,
    // Data side
    input wire bbc_dbus_s ds_i,
    output logic [7:0] ds_rdata_o = 8'h00
);
    logic [7:0] rom [4096];
    // Plain bytes only; the bench never bit-modifies port-like places
    logic [7:0] ram [256];
    // The address flop sits in the decoder, so the byte follows it within the cycle
    assign pm_data_o = rom[pm_addr_i];
    // Read data toggles when no strobe came, so a late or early sample shows up
    always @(posedge mclk_i) begin
        ds_rdata_o <= ds_i.rd ? ram[ds_i.addr] : ~ds_rdata_o;
        if (ds_i.wr) begin
            ram[ds_i.addr] <= ds_i.wdata;
        end
    end
endmodule : bbc_mem_model

//--- bench/branch_bit_control_decoder_tb.sv
// Self-checking bench for the branch, bit and control decoder
`timescale 1ns/100ps
module branch_bit_control_decoder_tb import bbc_pkg::*;;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wdog_sel_i = 1'b0;
    logic wake_i = 1'b0;
    bbc_flags_s saved_flags_i = '0;
    bbc_pc_t pm_addr_o;
    logic [7:0] pm_data_i;
    bbc_dbus_s ds_o;
    logic [7:0] ds_rdata_i;
    bbc_flags_s flags_o;
    logic stop_o;
    logic wait_o;
    logic ext_valid_o;
    logic [7:0] ext_opcode_o;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;

    bbc_decoder i_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
        .ds_o(ds_o), .ds_rdata_i(ds_rdata_i),
        .wdog_sel_i(wdog_sel_i), .wake_i(wake_i), .saved_flags_i(saved_flags_i),
        .flags_o(flags_o), .stop_o(stop_o), .wait_o(wait_o),
        .ext_valid_o(ext_valid_o), .ext_opcode_o(ext_opcode_o)
    );
    bbc_mem_model i_mem (
        .mclk_i(mclk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
        .ds_i(ds_o), .ds_rdata_o(ds_rdata_i)
    );

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // Whole run needs about 1500 cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wait_ext(output int n);
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (ext_valid_o !== 1'b1 && n < 300);
    endtask : wait_ext

    // Call, interrupt return to load flags, long jump to the marker at 180h
    task prep();
        for (int a = 0; a < 4096; a++) begin
            i_mem.rom[a] = 8'h0f;
        end
        i_mem.rom[0] = 8'h31;
        i_mem.rom[1] = 8'h00;
        i_mem.rom[2] = 8'h19;
        i_mem.rom[3] = 8'h80;
        i_mem.rom[12'h300] = 8'h4d;
        i_mem.rom[12'h180] = 8'h05;
    endtask : prep

    task start(input logic [1:0] fl);
        int k;
        saved_flags_i = fl;
        rst_b_i = 1'b0;
        repeat (10) @(negedge mclk_i);
        rst_b_i = 1'b1;
        wait_ext(k);
        chk("first marker", 12'h005, 12'(ext_opcode_o));
    endtask : start

    // Marker to marker: two cycles of the marker plus the cycles under test
    task go(input logic [1:0] fl, input int n, input logic [1:0] efl);
        int k;
        start(fl);
        wait_ext(k);
        chk("cycles", 12'(n), 12'(k));
        chk("target marker", 12'h007, 12'(ext_opcode_o));
        chk("flags", 12'(efl), 12'(flags_o));
    endtask : go

    task test_rel();
        bit tk;
        bbc_pc_t tgt;
        for (int i = 0; i < 16; i++) begin
            prep();
            tk = (i[3:2] == 0) ? !i[1] : (i[3:2] == 1) ? !i[0] : (i[3:2] == 2) ? i[1] : i[0];
            tgt = !tk ? 12'h182 : i[0] ? 12'h191 : 12'h172;
            i_mem.rom[12'h181] = {i[0] ? 5'h0f : 5'h10, i[3:2], 1'b0};
            i_mem.rom[tgt] = 8'h07;
            go(i[1:0], 4, i[1:0]);
        end
        $display("relative branch test done");
    endtask : test_rel

    task test_btb();
        logic bv;
        bbc_pc_t tgt;
        for (int i = 0; i < 16; i++) begin
            prep();
            i_mem.ram[8'h40] = 8'h69;
            bv = 1'(8'h69 >> i[2:0]);
            tgt = (bv != i[3]) ? 12'h184 : i[0] ? 12'h202 : 12'h103;
            i_mem.rom[12'h181] = {i[0], i[1], i[2], i[3], 4'h3};
            i_mem.rom[12'h182] = 8'h40;
            i_mem.rom[12'h183] = i[0] ? 8'h7f : 8'h80;
            i_mem.rom[tgt] = 8'h07;
            go({1'b1, !bv}, 7, {1'b1, bv});
        end
        $display("bit test branch test done");
    endtask : test_btb

    task test_bsc();
        logic [7:0] m;
        for (int i = 0; i < 16; i++) begin
            prep();
            i_mem.ram[8'h41] = 8'h69;
            m = 8'h01 << i[2:0];
            i_mem.rom[12'h181] = {i[0], i[1], i[2], i[3], 4'hb};
            i_mem.rom[12'h182] = 8'h41;
            i_mem.rom[12'h183] = 8'h07;
            go({i[0], !i[0]}, 6, {i[0], !i[0]});
            chk("bit op byte", 12'(i[3] ? 8'h69 | m : 8'h69 & ~m), 12'(i_mem.ram[8'h41]));
        end
        $display("bit set clear test done");
    endtask : test_bsc

    task test_ctrl();
        prep();
        i_mem.rom[12'h181] = 8'h04;
        i_mem.rom[12'h182] = 8'h07;
        go(2'b10, 4, 2'b10);
        prep();
        i_mem.rom[12'h181] = 8'h59;
        i_mem.rom[12'h182] = 8'ha7;
        i_mem.rom[12'h5a7] = 8'h07;
        go(2'b01, 6, 2'b01);
        prep();
        i_mem.rom[12'h181] = 8'h61;
        i_mem.rom[12'h182] = 8'h20;
        i_mem.rom[12'h620] = 8'hcd;
        i_mem.rom[12'h183] = 8'h07;
        go(2'b11, 8, 2'b11);
        $display("control and long jump test done");
    endtask : test_ctrl

    // Stop without watchdog, stop with watchdog, plain wait
    task test_halt();
        int k;
        for (int i = 0; i < 3; i++) begin
            prep();
            i_mem.rom[12'h181] = (i == 2) ? 8'hed : 8'h6d;
            i_mem.rom[12'h182] = 8'h07;
            wdog_sel_i = (i == 1);
            start(2'b00);
            repeat (6) @(negedge mclk_i);
            chk("stop state", 12'(i == 0), 12'(stop_o));
            chk("wait state", 12'(i != 0), 12'(wait_o));
            wake_i = 1'b1;
            wait_ext(k);
            wake_i = 1'b0;
            chk("after wake", 12'h007, 12'(ext_opcode_o));
            chk("halt left", 12'h000, 12'({stop_o, wait_o}));
        end
        wdog_sel_i = 1'b0;
        $display("halt test done");
    endtask : test_halt

    initial begin
        @(negedge mclk_i);
        test_rel();
        test_btb();
        test_bsc();
        test_ctrl();
        test_halt();
        print_verdict();
    end
endmodule : branch_bit_control_decoder_tb
